/* File: src/vip_ctrl.sv */
// Interrupt qualification, priority, stacking and vectoring engine.
// Assumes a classic Wishbone master and a one-byte memory port answering next cycle.
`include "vip_cfg.svh"
module vip_ctrl #(
   parameter int NSRC = `VIP_NUM_SRC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Peripheral events, one pulse per cause
   input wire logic keyboard_wake_evt_i,
   input wire logic periodic_tick_evt_i,
   input wire logic wake_id_evt_i,
   input wire logic carrier_detect_evt_i,
   input wire logic decode_error_evt_i,
   input wire logic byte_received_evt_i,
   input wire logic tx_buffer_sent_evt_i,
   input wire logic tx_error_evt_i,
   input wire logic measurement_delay_evt_i,
   input wire logic timer_overflow_evt_i,
   input wire logic channel_one_evt_i,
   input wire logic channel_zero_evt_i,
   input wire logic wakeup_timer_evt_i,
   input wire logic low_supply_evt_i,
   // CPU side
   input wire logic instr_boundary_i,
   input wire logic software_trap_instruction_i,
   input wire logic return_from_handler_i,
   input wire logic firmware_active_i,
   input wire logic [15:0] next_pc_i,
   input wire logic [7:0] index_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] condition_code_register_i,
   input wire logic [7:0] sp_i,
   input wire logic cc_load_i,
   // Memory port
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_adr_o,
   output logic [7:0] mem_wdat_o,
   input wire logic [7:0] mem_rdat_i,
   // Results to CPU
   output logic [15:0] pc_o,
   output logic [7:0] sp_o,
   output logic [7:0] condition_code_register_o,
   output logic [7:0] index_o,
   output logic [7:0] acc_o,
   output logic restore_o,
   output logic busy_o,
   output logic stop_wake_o
);
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] CCR_RST = `VIP_CCR_RESET;
   vip_pkg::vip_state_e state;
   vip_pkg::vip_frame_s frame;
   logic [13:0] flags;
   logic [12:0] enables;
   logic [5:0] wakeup_interval_field;
   logic [NSRC-1:0] req;
   logic [3:0] win_vec;
   logic win_any;
   logic [2:0] cnt;
   logic [15:0] vec_adr;
   logic [15:0] fetch_pc;
   logic swi_pend;
   logic [13:0] evt;
   logic [13:0] wclr;
   logic bus_hit;
   logic [31:0] rdata;
   logic mask;
   logic frame_valid_entry;
   logic in_return;
   localparam logic [15:0] TRAP_ADR = 16'(`VIP_VEC_TOP) - 16'(2 * `VIP_VEC_SWI);
   localparam logic [12:0] EN_RST = 13'(`VIP_ENABLES_RESET);
   ////////////////////////////////////////////////////////////////////////
   assign evt = {low_supply_evt_i, wakeup_timer_evt_i, channel_zero_evt_i, channel_one_evt_i,
      timer_overflow_evt_i, measurement_delay_evt_i, tx_error_evt_i, tx_buffer_sent_evt_i,
      byte_received_evt_i, decode_error_evt_i, carrier_detect_evt_i, wake_id_evt_i,
      periodic_tick_evt_i, keyboard_wake_evt_i};
   // Ack in flight blocks a second take of the same request
   assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Clear per byte lane, as the enables are written
   always_comb begin
      wclr = 14'h0000;
      if (bus_hit && wb_we_i && wb_adr_i == 8'(`VIP_REG_FLAGS)) begin
         if (wb_sel_i[0]) wclr[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) wclr[13:8] = wb_dat_i[13:8];
      end
   end
   assign mask = condition_code_register_o[`VIP_CCR_I_BIT];
   ////////////////////////////////////////////////////////////////////////
   // Flags: write one clears, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 14'h0000;
      end else begin
         flags <= (flags & ~wclr) | evt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enables <= EN_RST;
         wakeup_interval_field <= 6'h00;
      end else if (bus_hit && wb_we_i && wb_adr_i == 8'(`VIP_REG_ENABLES)) begin
         if (wb_sel_i[0]) enables[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) enables[12:8] <= wb_dat_i[12:8];
         if (wb_sel_i[2]) wakeup_interval_field <= wb_dat_i[21:16];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Request per vector slot
   always_comb begin
      req = '0;
      req[15] = flags[0] && enables[0];
      req[12] = flags[1] && enables[1];
      req[11] = |(flags[5:2] & enables[5:2]) && !firmware_active_i;
      req[9] = (flags[6] || flags[7]) && enables[6];
      req[8] = flags[8] && enables[7] && !firmware_active_i;
      req[7] = flags[9] && enables[8];
      req[6] = flags[10] && enables[9];
      req[5] = flags[11] && enables[10];
      req[4] = flags[12] && (wakeup_interval_field != 6'h00);
      req[3] = flags[13] && enables[11];
   end
   // Slots 0 to 2 are never requested by events
   // lowest number, highest address, wins
   always_comb begin
      win_vec = 4'h0;
      win_any = 1'b0;
      for (int i = NSRC - 1; i >= 2; i--) begin
         if (req[i]) begin
            win_vec = 4'(i);
            win_any = 1'b1;
         end
      end
   end
   assign vec_adr = 16'(`VIP_VEC_TOP) - 16'({win_vec, 1'b0});
   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= vip_pkg::VIP_IDLE;
         cnt <= 3'h0;
         sp_o <= `VIP_SP_RESET;
         condition_code_register_o <= CCR_RST;
         pc_o <= `VIP_PC_RESET;
         frame <= '0;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_adr_o <= 16'h0000;
         mem_wdat_o <= 8'h00;
         index_o <= 8'h00;
         acc_o <= 8'h00;
         restore_o <= 1'b0;
         busy_o <= 1'b0;
         fetch_pc <= 16'h0000;
         swi_pend <= 1'b0;
      end else begin
         restore_o <= 1'b0;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         // Software loads of the condition codes land only while idle
         if (cc_load_i && state == vip_pkg::VIP_IDLE) begin
            condition_code_register_o <= condition_code_register_i;
         end
         unique case (state)
            vip_pkg::VIP_IDLE: begin
               busy_o <= 1'b0;
               if (instr_boundary_i && (software_trap_instruction_i || (win_any && !mask))) begin
                  frame <= '{cc: condition_code_register_o, acc: acc_i, idx: index_i, pc: next_pc_i};
                  swi_pend <= software_trap_instruction_i;
                  sp_o <= sp_i;
                  cnt <= 3'h0;
                  busy_o <= 1'b1;
                  state <= vip_pkg::VIP_PUSH;
               end else if (instr_boundary_i && return_from_handler_i) begin
                  sp_o <= sp_i;
                  cnt <= 3'h0;
                  busy_o <= 1'b1;
                  state <= vip_pkg::VIP_POP;
               end
            end
            vip_pkg::VIP_PUSH: begin
               // pc low first, condition codes last
               mem_req_o <= 1'b1;
               mem_we_o <= 1'b1;
               mem_adr_o <= {8'h00, sp_o};
               unique case (cnt)
                  3'h0: mem_wdat_o <= frame.pc[7:0];
                  3'h1: mem_wdat_o <= frame.pc[15:8];
                  3'h2: mem_wdat_o <= frame.idx;
                  3'h3: mem_wdat_o <= frame.acc;
                  default: mem_wdat_o <= frame.cc;
               endcase
               // ends one below the last byte
               sp_o <= sp_o - 8'h01;
               cnt <= cnt + 3'h1;
               if (cnt == 3'h4) begin
                  condition_code_register_o[`VIP_CCR_I_BIT] <= 1'b1;
                  state <= vip_pkg::VIP_VECH;
               end
            end
            vip_pkg::VIP_VECH: begin
               mem_req_o <= 1'b1;
               mem_adr_o <= swi_pend ? TRAP_ADR : vec_adr;
               cnt <= 3'h0;
               state <= vip_pkg::VIP_VECL;
            end
            vip_pkg::VIP_VECL: begin
               if (cnt == 3'h0) begin
                  mem_req_o <= 1'b1;
                  mem_adr_o <= mem_adr_o + 16'h0001;
                  // Last pop of a return also steps the stack pointer
                  if (in_return) begin
                     sp_o <= sp_o + 8'h01;
                  end
                  cnt <= 3'h1;
               end else if (cnt == 3'h1) begin
                  fetch_pc[15:8] <= mem_rdat_i;
                  cnt <= 3'h2;
               end else begin
                  fetch_pc[7:0] <= mem_rdat_i;
                  cnt <= 3'h0;
                  state <= vip_pkg::VIP_FILL;
               end
            end
            vip_pkg::VIP_FILL, vip_pkg::VIP_RFILL: begin
               mem_req_o <= cnt != 3'h3;
               mem_adr_o <= fetch_pc + 16'(cnt);
               cnt <= cnt + 3'h1;
               if (cnt == 3'h3) begin
                  pc_o <= fetch_pc;
                  restore_o <= state == vip_pkg::VIP_RFILL;
                  busy_o <= 1'b0;
                  state <= vip_pkg::VIP_IDLE;
               end
            end
            vip_pkg::VIP_POP: begin
               // reverse order pop
               // Read data lands two edges after its request
               cnt <= cnt + 3'h1;
               if (cnt[0] == 1'b0) begin
                  mem_req_o <= 1'b1;
                  mem_adr_o <= {8'h00, sp_o + 8'h01};
                  sp_o <= sp_o + 8'h01;
               end
               unique case (cnt)
                  3'h2: begin
                     condition_code_register_o <= mem_rdat_i;
                  end
                  3'h4: begin
                     acc_o <= mem_rdat_i;
                  end
                  3'h6: begin
                     index_o <= mem_rdat_i;
                     // Program counter bytes share the vector read path
                     swi_pend <= 1'b1;
                     cnt <= 3'h0;
                     state <= vip_pkg::VIP_VECL;
                  end
                  default: ;
               endcase
            end
            default: state <= vip_pkg::VIP_IDLE;
         endcase
         // Return path rejoins the vector read, then refills
         if (state == vip_pkg::VIP_VECL && cnt == 3'h2 && swi_pend && !frame_valid_entry) begin
            state <= vip_pkg::VIP_RFILL;
         end
      end
   end
   // Distinguishes return path from entry path after shared low-byte read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_return <= 1'b0;
      end else if (state == vip_pkg::VIP_IDLE) begin
         in_return <= 1'b0;
      end else if (state == vip_pkg::VIP_POP) begin
         in_return <= 1'b1;
      end
   end
   assign frame_valid_entry = !in_return;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_wake_o <= 1'b0;
      end else begin
         stop_wake_o <= state == vip_pkg::VIP_VECH;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Wishbone readback, ack one cycle after strobe
   always_comb begin
      unique case (wb_adr_i)
         8'(`VIP_REG_CTRL): rdata = {24'h0, condition_code_register_o};
         8'(`VIP_REG_FLAGS): rdata = {18'h0, flags};
         8'(`VIP_REG_ENABLES): rdata = {10'h0, wakeup_interval_field, 3'h0, enables};
         8'(`VIP_REG_STATUS): rdata = {16'h0, req};
         8'(`VIP_REG_VECTOR): rdata = {11'h0, win_any, win_vec, vec_adr};
         8'(`VIP_REG_FRAME): rdata = {state != vip_pkg::VIP_IDLE, 7'h0, sp_o, pc_o};
         default: rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_hit;
         wb_dat_o <= (bus_hit && !wb_we_i) ? rdata : 32'h0000_0000;
      end
   end
endmodule

/* File: common/vip_cfg.svh */
// Constants for the vectored interrupt priority block.
// Assumes inclusion by the package and the design file only.
`ifndef VIP_CFG_SVH
`define VIP_CFG_SVH
`define VIP_NUM_SRC 16
`define VIP_VEC_TOP 16'hdffe
`define VIP_VEC_BASE 16'hdfe0
`define VIP_SP_RESET 8'hff
`define VIP_PC_RESET 16'h0000
`define VIP_CCR_RESET 8'h68
`define VIP_CCR_I_BIT 3
`define VIP_REG_CTRL 32'h00
`define VIP_REG_FLAGS 32'h04
`define VIP_REG_ENABLES 32'h08
`define VIP_REG_STATUS 32'h0c
`define VIP_REG_VECTOR 32'h10
`define VIP_REG_FRAME 32'h14
`define VIP_CTRL_RESET 32'h0000_0001
`define VIP_ENABLES_RESET 32'h0000_0000
`define VIP_VEC_SWI 1
`define VIP_VEC_RESET 0
`endif

/* File: common/vip_pkg.sv */
// Types shared by the vectored interrupt priority block.
// Assumes vip_cfg.svh is on the include path.
`include "vip_cfg.svh"
package vip_pkg;
   typedef enum logic [6:0] {
      VIP_IDLE  = 7'b000_0001,
      VIP_PUSH  = 7'b000_0010,
      VIP_VECH  = 7'b000_0100,
      VIP_VECL  = 7'b000_1000,
      VIP_FILL  = 7'b001_0000,
      VIP_POP   = 7'b010_0000,
      VIP_RFILL = 7'b100_0000
   } vip_state_e;
   typedef struct packed {
      logic [7:0] cc;
      logic [7:0] acc;
      logic [7:0] idx;
      logic [15:0] pc;
   } vip_frame_s;
endpackage

/* File: dv/vip_mem_model.sv */
// Byte memory on the far side of the engine's memory port.
// Assumes one request at a time, read data wanted the cycle after.
module vip_mem_model (
   input wire logic clk_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_adr_i,
   input wire logic [7:0] mem_wdat_i,
   output logic [7:0] mem_rdat_o,
   output int rd_cnt_o
);
   logic [7:0] mem [0:65535];
   logic [15:0] wlog [$];
   ////////////////////////////////////////
   initial begin
      rd_cnt_o = 0;
      mem_rdat_o = 8'h00;
      for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h3c;
      for (int v = 0; v < 16; v++) begin
         mem[16'hdffe - 2 * v] = 8'(8'h40 + v);
         mem[16'hdfff - 2 * v] = 8'(8'h20 + v);
      end
   end
   ////////////////////////////////////////
   // Idle data toggles so stale bytes never look valid
   always @(posedge clk_i) begin
      if (mem_req_i && mem_we_i) begin
         mem[mem_adr_i] <= mem_wdat_i;
         wlog.push_back({mem_adr_i[7:0], mem_wdat_i});
      end else if (mem_req_i) begin
         mem_rdat_o <= mem[mem_adr_i];
         rd_cnt_o <= rd_cnt_o + 1;
      end else mem_rdat_o <= ~mem_rdat_o;
   end
endmodule

/* File: dv/vip_ctrl_properties.sv */
// Port-level checks of the interrupt engine.
// Assumes it is bound to the engine's top module.
module vip_ctrl_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic instr_boundary_i,
   input wire logic software_trap_instruction_i,
   input wire logic return_from_handler_i,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [7:0] condition_code_register_o,
   input wire logic [7:0] sp_o,
   input wire logic restore_o,
   input wire logic busy_o,
   input wire logic stop_wake_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_trap;
      instr_boundary_i && software_trap_instruction_i && !busy_o;
   endsequence
   sequence s_masked;
      instr_boundary_i && !busy_o && !software_trap_instruction_i && !return_from_handler_i
         && condition_code_register_o[3];
   endsequence
   ////////////////////////////////////////
   ack_next_a: assert property (s_wb_req |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   reset_mask_a: assert property ($fell(rst_i) |-> condition_code_register_o[3] && sp_o == 8'hff)
      else $error("mask clear after reset");
   masked_idle_a: assert property (s_masked |=> !busy_o) else $error("masked entry");
   trap_entry_a: assert property (s_trap |=> busy_o) else $error("trap ignored");
   wake_mask_a: assert property (stop_wake_o |-> busy_o && condition_code_register_o[3])
      else $error("fetch unmasked");
   wake_pulse_a: assert property (stop_wake_o |=> !stop_wake_o) else $error("wake held");
   push_busy_a: assert property (mem_req_o && mem_we_o |-> busy_o) else $error("stray push");
   restore_pulse_a: assert property (restore_o |=> !restore_o) else $error("restore held");
endmodule
bind vip_ctrl vip_ctrl_properties i_vip_ctrl_properties (.*);

/* File: dv/tb_vip_ctrl.sv */
// Self-checking bench for the interrupt engine.
// Assumes the memory model answers the engine's memory port.
module tb_vip_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bnd = 0, trap = 0, ret = 0, fw = 0, ccld = 0;
   logic [7:0] adr = 8'h00, cci = 8'h60, sp = 8'hf0, rdat, cc_o, sp_o, x_o, a_o, wdat;
   logic [31:0] dat = 32'h0, q, rd_o;
   logic [13:0] evt = 14'h0;
   logic [15:0] madr, pc_o;
   logic ack, mreq, mwe, rest, busy, wake;
   int failures = 0, samples_checked = 0, cycles = 0, wakes = 0, restores = 0, rd0;
   vip_ctrl i_vip_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack),
      .keyboard_wake_evt_i(evt[0]), .periodic_tick_evt_i(evt[1]), .wake_id_evt_i(evt[2]),
      .carrier_detect_evt_i(evt[3]), .decode_error_evt_i(evt[4]), .byte_received_evt_i(evt[5]),
      .tx_buffer_sent_evt_i(evt[6]), .tx_error_evt_i(evt[7]), .measurement_delay_evt_i(evt[8]),
      .timer_overflow_evt_i(evt[9]), .channel_one_evt_i(evt[10]), .channel_zero_evt_i(evt[11]),
      .wakeup_timer_evt_i(evt[12]), .low_supply_evt_i(evt[13]), .instr_boundary_i(bnd),
      .software_trap_instruction_i(trap), .return_from_handler_i(ret), .firmware_active_i(fw),
      .next_pc_i(16'h1234), .index_i(8'h5a), .acc_i(8'ha5), .condition_code_register_i(cci), .sp_i(sp),
      .cc_load_i(ccld), .mem_req_o(mreq), .mem_we_o(mwe), .mem_adr_o(madr), .mem_wdat_o(wdat),
      .mem_rdat_i(rdat), .pc_o(pc_o), .sp_o(sp_o), .condition_code_register_o(cc_o), .index_o(x_o),
      .acc_o(a_o), .restore_o(rest), .busy_o(busy), .stop_wake_o(wake));
   vip_mem_model i_mem (.clk_i(clk_i), .mem_req_i(mreq), .mem_we_i(mwe), .mem_adr_i(madr),
      .mem_wdat_i(wdat), .mem_rdat_o(rdat), .rd_cnt_o());
   ////////////////////////////////////////
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      wakes += (wake === 1'b1);
      restores += (rest === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rd_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic drive(input logic [13:0] e, input logic [7:0] c, input logic ld, input logic t, input logic r);
      @(posedge clk_i);
      evt <= e;
      cci <= c;
      ccld <= ld;
      bnd <= t | r | !(ld | (|e));
      trap <= t;
      ret <= r;
      @(posedge clk_i);
      {evt, ccld, bnd, trap, ret} <= '0;
   endtask
   task automatic run(input logic t, input logic r);
      rd0 = i_mem.rd_cnt_o;
      wakes = 0;
      restores = 0;
      i_mem.wlog.delete();
      drive(14'h0, cci, 1'b0, t, r);
      while (busy !== 1'b1) @(posedge clk_i);
      while (busy !== 1'b0) @(posedge clk_i);
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////
   task automatic t_entry();
      logic [7:0] fr [5] = '{8'h34, 8'h12, 8'h5a, 8'ha5, 8'h60};
      wb(1'b0, 8'h08, 32'h0);
      cmp("enables", 32'h0, q);
      wb(1'b0, 8'h20, 32'h0);
      cmp("unmapped", 32'h0, q);
      cmp("reset ccr", 32'h68, cc_o);
      wb(1'b1, 8'h08, 32'h0000_0801);
      drive(14'h0, 8'h60, 1'b1, 1'b0, 1'b0);
      drive(14'h2001, 8'h60, 1'b0, 1'b0, 1'b0);
      wb(1'b0, 8'h04, 32'h0);
      cmp("flags", 32'h2001, q);
      run(1'b0, 1'b0);
      for (int k = 0; k < 5; k++) cmp("push", {8'(8'hf0 - k), fr[k]}, i_mem.wlog[k]);
      cmp("frame size", 5, i_mem.wlog.size());
      cmp("sp after", 32'heb, sp_o);
      cmp("handler", 32'h4323, pc_o);
      cmp("mask", 32'h1, cc_o[3]);
      cmp("reads", 5, i_mem.rd_cnt_o - rd0);
      cmp("wakes", 1, wakes);
   endtask
   task automatic t_return();
      wb(1'b1, 8'h04, 32'h2000);
      sp <= 8'heb;
      run(1'b0, 1'b1);
      cmp("restored", 32'h01_1234_60, {restores[7:0], pc_o, cc_o});
      cmp("regs", 32'h5aa5f0, {x_o, a_o, sp_o});
      cmp("reads", 8, i_mem.rd_cnt_o - rd0);
      run(1'b0, 1'b0);
      cmp("keyboard", 32'h4f2f, pc_o);
   endtask
   task automatic t_trap();
      drive(14'h0001, 8'h68, 1'b1, 1'b0, 1'b0);
      drive(14'h0, 8'h68, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk_i);
      cmp("masked", 32'h0, busy);
      run(1'b1, 1'b0);
      cmp("trap", 32'h4121, pc_o);
      wb(1'b1, 8'h04, 32'h0001);
   endtask
   task automatic t_fw();
      wb(1'b1, 8'h08, 32'h0000_0004);
      drive(14'h0005, 8'h60, 1'b1, 1'b0, 1'b0);
      fw <= 1'b1;
      drive(14'h0, 8'h60, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk_i);
      cmp("blocked", 32'h0, busy);
      fw <= 1'b0;
      run(1'b0, 1'b0);
      cmp("receiver", 32'h4b2b, pc_o);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_entry();
      t_return();
      t_trap();
      t_fw();
      complete_run();
   end
endmodule
